// ---- logic/tmr8_params.svh ----
// Purpose: Register map, field positions, reset values and prescale masks of the 8-bit timer
// Assumes: Included by bare name from the timer module
// Notes: Definitions only
`ifndef TMR8_PARAMS_SVH
`define TMR8_PARAMS_SVH

// Register byte offsets
`define TMR8_OFF_CTRL 8'h00
`define TMR8_OFF_COUNT 8'h04
`define TMR8_OFF_COMPARE 8'h08
`define TMR8_OFF_FLAGS 8'h0C
`define TMR8_OFF_STATUS 8'h10

// Control register fields
`define TMR8_CTRL_WGM_LO 0
`define TMR8_CTRL_COM_LO 2
`define TMR8_CTRL_CS_LO 4
`define TMR8_CTRL_FORCE 7
`define TMR8_CTRL_DIR 8

// Flag register fields
`define TMR8_FLAG_OVF 0
`define TMR8_FLAG_CMP 1

// Counter extremes and reset values
`define TMR8_MAX 8'hFF
`define TMR8_BOTTOM 8'h00
`define TMR8_RST_COUNT 8'h00
`define TMR8_RST_COMPARE 8'h00

// Prescaler masks for divide by 1, 8, 32, 64, 128, 256, 1024
`define TMR8_MASK_1 10'h000
`define TMR8_MASK_8 10'h007
`define TMR8_MASK_32 10'h01F
`define TMR8_MASK_64 10'h03F
`define TMR8_MASK_128 10'h07F
`define TMR8_MASK_256 10'h0FF
`define TMR8_MASK_1024 10'h3FF

`endif

// ---- logic/tmr8_pkg.sv ----
// Purpose: Types shared by the 8-bit timer
// Assumes: Enum encodings are literal here; tmr8_params.svh is not included
// Notes: State of the timer module is one packed struct
package tmr8_pkg;
    // Waveform mode selection
    typedef enum logic [1:0] {
        TMR8_NORMAL = 2'b00,
        TMR8_PHASE = 2'b01,
        TMR8_CTC = 2'b10,
        TMR8_FAST = 2'b11
    } tmr8_mode_t;

    // Compare output action
    typedef enum logic [1:0] {
        TMR8_COM_OFF = 2'b00,
        TMR8_COM_TOGGLE = 2'b01,
        TMR8_COM_CLEAR = 2'b10,
        TMR8_COM_SET = 2'b11
    } tmr8_com_t;

    // Complete state of the timer
    typedef struct packed {
        logic [9:0] presc;
        logic [7:0] count_value;
        logic [7:0] compare_value;
        logic [7:0] compare_buf;
        tmr8_mode_t waveform_mode_sel;
        tmr8_com_t compare_output_action;
        logic [2:0] clk_sel;
        logic pin_dir_out;
        logic compare_output;
        logic overflow_flag;
        logic compare_match_flag;
        logic match_blocked;
        logic match_seen;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tmr8_state_t;
endpackage : tmr8_pkg

// ---- logic/tmr8_timer.sv ----
// Purpose: 8-bit timer/counter with one compare channel, APB register access
// Assumes: APB master on I_CORE_CLK; service inputs are one-cycle pulses on the same clock
// Notes: Normal, clear-on-compare and fast PWM modes; mode 1 counts as normal mode
// Function
// - Waveform mode sets counting; output action never changes the count sequence.
// - Output action picks PWM polarity, or set/clear/toggle on match otherwise.
// - Mode 0 only increments and wraps from 0xFF to 0x00.
// - Normal mode sets overflow flag as count becomes zero; counting never clears it.
// - Servicing the overflow interrupt clears the overflow flag.
// - Normal mode accepts a new count write at any time.
// - Mode 2 clears the count when it equals the compare value.
// - Clear-on-compare raises the compare flag each time count reaches top.
// - Clear-on-compare compare writes act at once; a missed match wraps via 0xFF.
// - Clear-on-compare with action 1 toggles the output on every match.
// - Output reaches the pin only while its direction is output.
// - Timer tick is the core clock divided by 1, 8, 32, 64, 128, 256 or 1024.
// - Clear-on-compare sets overflow flag when count wraps from maximum to 0x00 without a match.
// - Mode 3 counts single-slope from bottom to maximum, then restarts.
// - Fast PWM non-inverting clears on match and sets at bottom.
// - Fast PWM inverting sets on match and clears at bottom.
// - Fast PWM counts to maximum then clears on the following tick.
// - Fast PWM action 2 is non-inverted, action 3 inverted.
// - Fast PWM sets overflow flag each time count reaches maximum.
// - Compare value is double buffered in PWM, loaded at top; direct otherwise.
// - A match sets the compare flag on the next timer tick.
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "tmr8_params.svh"

module tmr8_timer #(
    parameter int ADDR_W = 8
) (
    input wire logic I_CORE_CLK,
    input wire logic I_ARST_N,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [ADDR_W-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    input wire logic I_OVF_SERVICED,
    input wire logic I_CMP_SERVICED,
    output logic O_CMP_PIN,
    output logic O_CMP_PIN_OE
);
    import tmr8_pkg::*;

    tmr8_state_t st_r;
    tmr8_state_t st_nxt;
    logic acc;
    logic wr_ctrl;
    logic wr_count;
    logic wr_cmp;
    logic wr_flags;
    logic tick;
    logic hit;
    logic pwm;
    logic at_max;
    logic [9:0] mask;
    logic [7:0] addr;

    // Outputs straight from the state register
    assign O_PRDATA = st_r.prdata;
    assign O_PREADY = st_r.pready;
    assign O_PSLVERR = st_r.pslverr;
    assign O_CMP_PIN = st_r.compare_output;
    assign O_CMP_PIN_OE = st_r.pin_dir_out;

    // Next state of prescaler, counter, flags, output and bus slave
    always_comb begin
        st_nxt = st_r;
        addr = I_PADDR[7:0];
        acc = I_PSEL & I_PENABLE & st_r.pready;
        wr_ctrl = acc & I_PWRITE & (addr == `TMR8_OFF_CTRL);
        wr_count = acc & I_PWRITE & (addr == `TMR8_OFF_COUNT);
        wr_cmp = acc & I_PWRITE & (addr == `TMR8_OFF_COMPARE);
        wr_flags = acc & I_PWRITE & (addr == `TMR8_OFF_FLAGS);
        pwm = (st_r.waveform_mode_sel == TMR8_FAST);
        at_max = (st_r.count_value == `TMR8_MAX);
        hit = (st_r.count_value == st_r.compare_value) & ~st_r.match_blocked;

        // Prescale selection
        case (st_r.clk_sel)
            3'h1: mask = `TMR8_MASK_1;
            3'h2: mask = `TMR8_MASK_8;
            3'h3: mask = `TMR8_MASK_32;
            3'h4: mask = `TMR8_MASK_64;
            3'h5: mask = `TMR8_MASK_128;
            3'h6: mask = `TMR8_MASK_256;
            3'h7: mask = `TMR8_MASK_1024;
            default: mask = `TMR8_MASK_1;
        endcase
        tick = (st_r.clk_sel != 3'h0) && ((st_r.presc & mask) == mask);
        st_nxt.presc = (st_r.clk_sel == 3'h0) ? 10'h000 : st_r.presc + 10'h001;

        // Flag clears by software or interrupt service; sets below win
        if (wr_flags && I_PWDATA[`TMR8_FLAG_OVF]) begin
            st_nxt.overflow_flag = 1'b0;
        end
        if (wr_flags && I_PWDATA[`TMR8_FLAG_CMP]) begin
            st_nxt.compare_match_flag = 1'b0;
        end
        if (I_OVF_SERVICED) begin
            st_nxt.overflow_flag = 1'b0;
        end
        if (I_CMP_SERVICED) begin
            st_nxt.compare_match_flag = 1'b0;
        end

        // Timer tick: count, flags and waveform
        if (tick) begin
            st_nxt.match_blocked = 1'b0;
            st_nxt.match_seen = hit;
            if (st_r.match_seen) begin
                st_nxt.compare_match_flag = 1'b1;
            end
            if ((st_r.waveform_mode_sel == TMR8_CTC) && hit) begin
                st_nxt.count_value = `TMR8_BOTTOM;
            end else begin
                st_nxt.count_value = st_r.count_value + 8'h01;
            end
            if (at_max && !((st_r.waveform_mode_sel == TMR8_CTC) && hit)) begin
                st_nxt.overflow_flag = 1'b1;
            end
            if (pwm && at_max) begin
                st_nxt.compare_value = st_r.compare_buf;
            end
            if (hit) begin
                case (st_r.compare_output_action)
                    TMR8_COM_TOGGLE: st_nxt.compare_output = ~st_r.compare_output;
                    TMR8_COM_CLEAR: st_nxt.compare_output = 1'b0;
                    TMR8_COM_SET: st_nxt.compare_output = 1'b1;
                    default: st_nxt.compare_output = st_r.compare_output;
                endcase
            end
            // Bottom action wins so a top-valued compare gives a steady level
            if (pwm && at_max) begin
                case (st_r.compare_output_action)
                    TMR8_COM_CLEAR: st_nxt.compare_output = 1'b1;
                    TMR8_COM_SET: st_nxt.compare_output = 1'b0;
                    default: st_nxt.compare_output = st_nxt.compare_output;
                endcase
            end
        end

        // Control write; force strobe acts at once in non-PWM modes
        if (wr_ctrl) begin
            st_nxt.waveform_mode_sel = tmr8_mode_t'(I_PWDATA[`TMR8_CTRL_WGM_LO +: 2]);
            st_nxt.compare_output_action = tmr8_com_t'(I_PWDATA[`TMR8_CTRL_COM_LO +: 2]);
            st_nxt.clk_sel = I_PWDATA[`TMR8_CTRL_CS_LO +: 3];
            st_nxt.pin_dir_out = I_PWDATA[`TMR8_CTRL_DIR];
            if (I_PWDATA[`TMR8_CTRL_FORCE] && !pwm) begin
                case (tmr8_com_t'(I_PWDATA[`TMR8_CTRL_COM_LO +: 2]))
                    TMR8_COM_TOGGLE: st_nxt.compare_output = ~st_r.compare_output;
                    TMR8_COM_CLEAR: st_nxt.compare_output = 1'b0;
                    TMR8_COM_SET: st_nxt.compare_output = 1'b1;
                    default: st_nxt.compare_output = st_r.compare_output;
                endcase
            end
        end

        // Count write wins over a tick and blocks the next match
        if (wr_count) begin
            st_nxt.count_value = I_PWDATA[7:0];
            st_nxt.match_blocked = 1'b1;
            st_nxt.match_seen = 1'b0;
        end

        // Compare write goes to the buffer; direct outside PWM
        if (wr_cmp) begin
            st_nxt.compare_buf = I_PWDATA[7:0];
        end
        if (st_nxt.waveform_mode_sel != TMR8_FAST) begin
            st_nxt.compare_value = st_nxt.compare_buf;
        end

        // APB: answer in the first access cycle, read data captured at setup
        st_nxt.pready = I_PSEL & ~I_PENABLE;
        if (I_PSEL && !I_PENABLE) begin
            st_nxt.pslverr = 1'b0;
            case (addr)
                `TMR8_OFF_CTRL: st_nxt.prdata = {23'h000000, st_r.pin_dir_out, 1'b0,
                    st_r.clk_sel, st_r.compare_output_action, st_r.waveform_mode_sel};
                `TMR8_OFF_COUNT: st_nxt.prdata = {24'h000000, st_r.count_value};
                `TMR8_OFF_COMPARE: st_nxt.prdata = {24'h000000, st_r.compare_buf};
                `TMR8_OFF_FLAGS: st_nxt.prdata = {30'h00000000, st_r.compare_match_flag,
                    st_r.overflow_flag};
                `TMR8_OFF_STATUS: st_nxt.prdata = {31'h00000000, st_r.compare_output};
                default: begin
                    st_nxt.prdata = 32'h00000000;
                    st_nxt.pslverr = 1'b1;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st_r <= '0;
            st_r.count_value <= `TMR8_RST_COUNT;
            st_r.compare_value <= `TMR8_RST_COMPARE;
            st_r.compare_buf <= `TMR8_RST_COMPARE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Assertions run on the core clock and rest during reset
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_ARST_N);

    // Counting sequence in normal, clear-on-compare and fast PWM modes
    wrap_norm_a: assert property (
        tick && !wr_count && st_r.waveform_mode_sel == TMR8_NORMAL
        |=> st_r.count_value == $past(st_r.count_value) + 8'h01)
        else $error("normal mode count did not increment");
    ctc_clear_a: assert property (
        tick && hit && !wr_count && st_r.waveform_mode_sel == TMR8_CTC
        |=> st_r.count_value == 8'h00)
        else $error("clear-on-compare did not clear count");
    pwm_count_a: assert property (
        tick && pwm && !wr_count
        |=> st_r.count_value == $past(st_r.count_value) + 8'h01)
        else $error("fast PWM count did not run single-slope");
    count_wr_a: assert property (
        wr_count |=> st_r.count_value == $past(I_PWDATA[7:0]))
        else $error("count write did not land");
    idle_hold_a: assert property (
        !tick && !wr_count |=> $stable(st_r.count_value))
        else $error("count moved without a timer tick");

    // Overflow flag set, hold and clear
    ovf_norm_a: assert property (
        tick && !wr_count && at_max && st_r.waveform_mode_sel == TMR8_NORMAL
        |=> st_r.overflow_flag && st_r.count_value == 8'h00)
        else $error("overflow flag not set on wrap");
    ovf_ctc_a: assert property (
        tick && at_max && !hit && st_r.waveform_mode_sel == TMR8_CTC
        |=> st_r.overflow_flag)
        else $error("overflow flag not set on clear-on-compare wrap");
    ovf_pwm_a: assert property (
        tick && at_max && pwm |=> st_r.overflow_flag)
        else $error("overflow flag not set at PWM maximum");
    ovf_hold_a: assert property (
        st_r.overflow_flag && !I_OVF_SERVICED && !(wr_flags && I_PWDATA[0])
        |=> st_r.overflow_flag)
        else $error("overflow flag lost without a clear");
    ovf_srv_a: assert property (
        I_OVF_SERVICED && !(tick && at_max) |=> !st_r.overflow_flag)
        else $error("overflow flag not cleared by service");
    flag_gate_a: assert property (
        !tick |=> !$rose(st_r.overflow_flag) && !$rose(st_r.compare_match_flag))
        else $error("flag set without a timer tick");

    // Compare match flag and compare value
    match_latch_a: assert property (
        tick && hit && !wr_count |=> st_r.match_seen)
        else $error("compare match not latched");
    ocf_next_a: assert property (
        tick && st_r.match_seen |=> st_r.compare_match_flag)
        else $error("compare flag not set after match");
    ctc_direct_a: assert property (
        st_r.waveform_mode_sel == TMR8_CTC && wr_cmp && !wr_ctrl
        |=> st_r.compare_value == $past(I_PWDATA[7:0]))
        else $error("clear-on-compare compare write not direct");
    buf_hold_a: assert property (
        pwm && !(tick && at_max) && !wr_ctrl |=> $stable(st_r.compare_value))
        else $error("PWM compare value changed away from top");

    // Compare output actions and pin direction
    toggle_ctc_a: assert property (
        tick && hit && !wr_ctrl && st_r.compare_output_action == TMR8_COM_TOGGLE
        |=> st_r.compare_output != $past(st_r.compare_output))
        else $error("compare output did not toggle");
    pwm_clr_a: assert property (
        tick && hit && !at_max && pwm && st_r.compare_output_action == TMR8_COM_CLEAR
        |=> !st_r.compare_output)
        else $error("non-inverted output not cleared on match");
    pwm_bottom_a: assert property (
        tick && at_max && pwm && st_r.compare_output_action == TMR8_COM_CLEAR
        |=> st_r.compare_output)
        else $error("non-inverted output not set at bottom");
    pwm_set_a: assert property (
        tick && hit && !at_max && pwm && st_r.compare_output_action == TMR8_COM_SET
        |=> st_r.compare_output)
        else $error("inverted output not set on match");
    pwm_inv_a: assert property (
        tick && at_max && pwm && st_r.compare_output_action == TMR8_COM_SET
        |=> !st_r.compare_output)
        else $error("inverted output not cleared at bottom");
    out_gate_a: assert property (
        !tick && !wr_ctrl |=> $stable(st_r.compare_output))
        else $error("compare output moved without a timer tick");
    pin_dir_a: assert property (
        wr_ctrl |=> O_CMP_PIN_OE == $past(I_PWDATA[`TMR8_CTRL_DIR]))
        else $error("pin direction not taken from control write");

    // Bus answer timing
    apb_ready_a: assert property (
        I_PSEL && !I_PENABLE |=> O_PREADY)
        else $error("bus ready not raised in access cycle");
    apb_idle_a: assert property (
        !(I_PSEL && !I_PENABLE) |=> !O_PREADY)
        else $error("bus ready raised outside access cycle");
endmodule : tmr8_timer

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the 8-bit timer through APB and the compare pin
// Assumes: APB slave answers in its own time; register map of the timer control logic
// Notes: Pin periods and duty are counted in core clock cycles
`timescale 1ns/1ns
module tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ovf_srv = 1'b0;
    logic cmp_srv = 1'b0;
    logic pin;
    logic pin_oe;
    int failures = 0;
    int checks = 0;
    logic [31:0] rd;
    logic err;

    // Core clock, 50 ns period
    always #25 clk = ~clk;

    tmr8_timer tmr8_timer_i (.I_CORE_CLK(clk), .I_ARST_N(arst_n), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_OVF_SERVICED(ovf_srv), .I_CMP_SERVICED(cmp_srv),
        .O_CMP_PIN(pin), .O_CMP_PIN_OE(pin_oe));

    // Closing report, the only place where the run ends
    task automatic tally_and_finish();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    // Compare seen against expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (pready !== 1'b1) begin
            failures++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    // Cycles until the pin next changes level
    task automatic span(output int n);
        logic p;
        #1;
        p = pin;
        n = 0;
        while (pin === p && n < 5000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 5000) begin
            failures++;
            tally_and_finish();
        end
    endtask : span

    // Reset values and an unmapped access
    task automatic t_reset_map();
        apb(1'b0, 8'h00, 32'h0); chk(rd, 32'h0);
        apb(1'b0, 8'h04, 32'h0); chk(rd, 32'h0);
        apb(1'b0, 8'h14, 32'h0); chk({err, rd[30:0]}, 32'h80000000);
    endtask : t_reset_map

    // Normal mode: wrap, overflow flag, service clears it, count write while running
    task automatic t_normal();
        apb(1'b1, 8'h04, 32'hF0);
        apb(1'b1, 8'h00, 32'h10);
        idle(30);
        apb(1'b0, 8'h0C, 32'h0); chk(rd, 32'h3);
        @(posedge clk) ovf_srv <= 1'b1;
        @(posedge clk) ovf_srv <= 1'b0;
        apb(1'b0, 8'h0C, 32'h0); chk(rd, 32'h2);
        apb(1'b1, 8'h04, 32'h40);
        apb(1'b0, 8'h04, 32'h0); chk(32'(rd >= 32'h40 && rd < 32'h48), 32'h1);
    endtask : t_normal

    // Clear-on-compare toggle: counter bounded, flag, direction, prescale
    task automatic t_ctc();
        int n;
        int div[7] = '{1, 8, 32, 64, 128, 256, 1024};
        apb(1'b1, 8'h00, 32'h2);
        apb(1'b1, 8'h08, 32'h3);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b1, 8'h0C, 32'h3);
        apb(1'b1, 8'h00, 32'h116);
        repeat (3) begin
            apb(1'b0, 8'h04, 32'h0); chk(32'(rd <= 32'h3), 32'h1);
        end
        apb(1'b0, 8'h0C, 32'h0); chk(rd & 32'h2, 32'h2);
        chk(32'(pin_oe), 32'h1);
        span(n); span(n); chk(n, 32'd4);
        for (int s = 1; s <= 7; s++) begin
            apb(1'b1, 8'h08, 32'h1);
            apb(1'b1, 8'h00, 32'h106 | (s << 4));
            span(n); span(n); span(n); chk(n, 2 * div[s-1]);
        end
        apb(1'b1, 8'h00, 32'h16);
        idle(2);
        chk(32'(pin_oe), 32'h0);
    endtask : t_ctc

    // Compare lowered below count: match missed, count wraps through 0xFF
    task automatic t_missed();
        apb(1'b1, 8'h00, 32'h2);
        apb(1'b1, 8'h04, 32'h10);
        apb(1'b1, 8'h08, 32'h8);
        apb(1'b1, 8'h0C, 32'h3);
        apb(1'b1, 8'h00, 32'h12);
        idle(100);
        apb(1'b0, 8'h0C, 32'h0); chk(rd, 32'h0);
        idle(200);
        apb(1'b0, 8'h0C, 32'h0); chk(rd, 32'h3);
    endtask : t_missed

    // Fast PWM duty for both polarities, overflow at maximum
    task automatic t_pwm();
        int hi;
        for (int inv = 0; inv < 2; inv++) begin
            apb(1'b1, 8'h08, inv ? 32'h80 : 32'h40);
            apb(1'b1, 8'h00, 32'h11B | (inv << 2));
            apb(1'b1, 8'h0C, 32'h3);
            idle(300);
            hi = 0;
            for (int c = 0; c < 256; c++) begin
                @(posedge clk);
                #1;
                hi += int'(pin === 1'b1);
            end
            chk(hi, inv ? 32'd127 : 32'd65);
            apb(1'b0, 8'h0C, 32'h0); chk(rd, 32'h3);
        end
    endtask : t_pwm

    // Clock stopped: compare service clear, forced output, status and read-back
    task automatic t_force();
        apb(1'b1, 8'h00, 32'h102);
        @(posedge clk) cmp_srv <= 1'b1;
        @(posedge clk) cmp_srv <= 1'b0;
        apb(1'b1, 8'h00, 32'h18E);
        apb(1'b0, 8'h10, 32'h0); chk(rd, 32'h1);
        chk(32'(pin), 32'h1);
        apb(1'b1, 8'h00, 32'h18A);
        apb(1'b0, 8'h10, 32'h0); chk(rd, 32'h0);
        chk(32'(pin), 32'h0);
        apb(1'b0, 8'h0C, 32'h0); chk(rd, 32'h1);
        apb(1'b0, 8'h00, 32'h0); chk(rd, 32'h10A);
        apb(1'b0, 8'h08, 32'h0); chk(rd, 32'h80);
    endtask : t_force

    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        t_reset_map();
        t_normal();
        t_ctc();
        t_missed();
        t_pwm();
        t_force();
        tally_and_finish();
    end
endmodule : tb_top
